// file: logic/stim_port_override_select.sv
`timescale 1ns/1ps
// Summary of operation
// - modes one and two apply override only to ports chosen by the selection field
// - low zero bits are mask, then a one, upper bits give port prefix
// - five zeros then one picks 32 ports; only top bit picks all
// - mode zero disables override and ignores port selection
// - mode one makes selected-port writes guaranteed transactions
// - mode two makes selected writes invariant timing; mode three reserved
// - unselected ports pass through with their normal behaviour
// - master register holds master selection in upper bits, resets to zero
// - master enable clear at reset; override then applies to all masters
// - master enable set restricts override to selected masters
// - master selection uses the same mask-delimiter-prefix encoding
// - top-bit-only master selection picks all masters
// - with master selection, override needs both master and port selected
// - port register holds selection high, two-bit mode low, mode resets zero
module stim_port_override_select
    import override_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire sp_write_s   sp_in,
    output sp_write_s        sp_out
);

    // true when num lies in the block the mask-delimiter-prefix field names
    function automatic logic sel_match(input logic [SEL_W-1:0] sel,
                                       input logic [NUM_W-1:0] num);
        logic             hit;
        logic             found;
        logic [SEL_W-1:0] shifted;
        hit     = 1'b0;
        found   = 1'b0;
        shifted = {num, 1'b1};
        for (int n = 0; n < SEL_W; n++)
        begin
            // first one from the bottom is the delimiter; bits below ignored
            if (!found && sel[n])
            begin
                found = 1'b1;
                hit   = ((sel >> (n + 1))
                         == (shifted >> (n + 1)));
            end
        end
        return hit; // all-zero field never matches, undefined anyway
    endfunction

    logic [1:0]       mode_reg;
    logic [SEL_W-1:0] port_sel_reg;
    logic             mena_reg;
    logic [SEL_W-1:0] master_sel_reg;
    logic [11:0]      awaddr_reg;
    logic             aw_held_reg;
    logic [31:0]      wdata_reg;
    logic [3:0]       wstrb_reg;
    logic             w_held_reg;
    logic             awready_reg;
    logic             wready_reg;
    logic             bvalid_reg;
    logic [1:0]       bresp_reg;
    logic             arready_reg;
    logic             rvalid_reg;
    logic [31:0]      rdata_reg;
    logic [1:0]       rresp_reg;
    sp_write_s        sp_out_reg;

    wire aw_take = s_axi_awvalid && awready_reg;
    wire w_take  = s_axi_wvalid && wready_reg;
    wire ar_take = s_axi_arvalid && arready_reg;
    wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_port   = do_write && awaddr_reg[11:2] == PORT_OVR_OFFSET[11:2];
    wire wr_master = do_write && awaddr_reg[11:2] == MASTER_OVR_OFFSET[11:2];
    wire rd_port   = s_axi_araddr[11:2] == PORT_OVR_OFFSET[11:2];
    wire rd_master = s_axi_araddr[11:2] == MASTER_OVR_OFFSET[11:2];

    wire [31:0] port_word   = {port_sel_reg, 13'h0000, mode_reg};
    wire [31:0] master_word = {master_sel_reg, 14'h0000, mena_reg};
    wire [31:0] rd_word = rd_port ? port_word
                        : rd_master ? master_word : 32'h0000_0000;

    wire mode_on   = mode_reg == MODE_GUARANTEED || mode_reg == MODE_INVARIANT;
    wire port_hit  = sel_match(port_sel_reg, sp_in.port);
    wire mast_hit  = !mena_reg
                   || sel_match(master_sel_reg, sp_in.master);
    wire apply     = mode_on && port_hit && mast_hit;

    // byte lanes: high lanes carry the selection, lane 0 the mode bits or the master enable bit
    wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [31:0] port_new   = (port_word & ~wmask) | (wdata_reg & wmask);
    wire [31:0] master_new = (master_word & ~wmask) | (wdata_reg & wmask);

    sp_write_s sp_next;
    always_comb
    begin
        sp_next = sp_in;
        if (apply && mode_reg == MODE_GUARANTEED)
        begin
            sp_next.guaranteed = 1'b1;
            sp_next.invariant  = 1'b0;
        end
        if (apply && mode_reg == MODE_INVARIANT)
        begin
            sp_next.guaranteed = 1'b0;
            sp_next.invariant  = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode_reg       <= MODE_RESET;
            mena_reg       <= MENA_RESET;
            port_sel_reg   <= SEL_RESET;
            master_sel_reg <= SEL_RESET;
        end
        else
        begin
            if (wr_port)
            begin
                mode_reg     <= port_new[MODE_LSB +: 2];
                port_sel_reg <= port_new[SEL_LSB +: SEL_W];
            end
            if (wr_master)
            begin
                mena_reg       <= master_new[MENA_LSB];
                master_sel_reg <= master_new[SEL_LSB +: SEL_W];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= AXI_OKAY;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            awready_reg <= !aw_held_reg && !aw_take && !bvalid_reg;
            wready_reg  <= !w_held_reg && !w_take && !bvalid_reg;
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wr_port || wr_master) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= AXI_OKAY;
        end
        else
        begin
            arready_reg <= !rvalid_reg && !ar_take;
            if (ar_take)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= (rd_port || rd_master) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (rvalid_reg && s_axi_rready)
            begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // one register stage on the write path keeps every output a flop
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sp_out_reg <= '0;
        end
        else
        begin
            sp_out_reg <= sp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign sp_out        = sp_out_reg;

    property mode_off_pass;
        @(posedge clock) disable iff (reset)
        (mode_reg == MODE_OFF) |=> sp_out == $past(sp_in);
    endproperty
    mode_off_pass_a: assert property (mode_off_pass)
        else $error("override active while mode is off");

    unselected_pass_a: assert property (
        @(posedge clock) disable iff (reset)
        !port_hit |=> sp_out == $past(sp_in))
        else $error("unselected port altered");

    guaranteed_force_a: assert property (
        @(posedge clock) disable iff (reset)
        (sp_in.valid && mode_reg == MODE_GUARANTEED && port_hit && mast_hit)
        |=> sp_out.guaranteed && !sp_out.invariant)
        else $error("guaranteed override missing");

    invariant_force_a: assert property (
        @(posedge clock) disable iff (reset)
        (mode_reg == MODE_INVARIANT && port_hit && mast_hit)
        |=> sp_out.invariant && !sp_out.guaranteed)
        else $error("invariant override missing");

    master_gate_a: assert property (
        @(posedge clock) disable iff (reset)
        (mena_reg && !sel_match(master_sel_reg, sp_in.master))
        |=> sp_out == $past(sp_in))
        else $error("override on unselected master");

    master_all_a: assert property (
        @(posedge clock) disable iff (reset)
        (!mena_reg && mode_reg == MODE_GUARANTEED && port_hit)
        |=> sp_out.guaranteed)
        else $error("override blocked with master select off");

    reset_mode_a: assert property (
        @(posedge clock)
        reset |=> mode_reg == MODE_RESET && mena_reg == MENA_RESET)
        else $error("control bits not cleared by reset");

    all_ports_a: assert property (
        @(posedge clock) disable iff (reset)
        port_sel_reg == 17'h1_0000 |-> port_hit)
        else $error("all-port selection missed a port");

    write_resp_a: assert property (
        @(posedge clock) disable iff (reset)
        do_write |=> s_axi_bvalid)
        else $error("write response late");

    read_resp_a: assert property (
        @(posedge clock) disable iff (reset)
        ar_take |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
        else $error("read data wrong");

    cov_guar_c: cover property (@(posedge clock) disable iff (reset)
        sp_out.valid && sp_out.guaranteed && mode_reg == MODE_GUARANTEED);
    cov_inv_c: cover property (@(posedge clock) disable iff (reset)
        apply && mode_reg == MODE_INVARIANT);
    cov_mast_c: cover property (@(posedge clock) disable iff (reset)
        mena_reg && apply);
    cov_write_c: cover property (@(posedge clock) disable iff (reset)
        wr_port ##[1:20] wr_master);

endmodule

// file: common/override_pkg.sv
package override_pkg;

    localparam int SEL_W = 17;
    localparam int NUM_W = 16;

    // byte offsets of the two registers on the slave
    localparam logic [11:0] PORT_OVR_OFFSET   = 12'h0000;
    localparam logic [11:0] MASTER_OVR_OFFSET = 12'h0004;

    localparam int SEL_LSB  = 15;
    localparam int MODE_LSB = 0;
    localparam int MENA_LSB = 0;

    localparam logic [1:0]       MODE_RESET = 2'h0;
    localparam logic             MENA_RESET = 1'b0;
    localparam logic [SEL_W-1:0] SEL_RESET  = 17'h0_0000;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        MODE_OFF,
        MODE_GUARANTEED,
        MODE_INVARIANT,
        MODE_RESERVED
    } override_mode_e;

    typedef struct packed
    {
        logic             valid;
        logic [NUM_W-1:0] port;
        logic [NUM_W-1:0] master;
        logic             guaranteed;
        logic             invariant;
    } sp_write_s;

endpackage

// file: test/sp_source.sv
`timescale 1ns/1ps
module sp_source
    import override_pkg::*;
(
    input  wire logic clock,
    output sp_write_s sp
);
    initial sp = '0;
    // idle cycle scrambles fields so stale data never looks fresh
    task automatic send(input sp_write_s d);
        @(posedge clock);
        sp <= d;
        @(posedge clock);
        sp <= {1'b0, ~d[33:0]};
    endtask
endmodule

// file: test/stim_port_override_select_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module stim_port_override_select_tb;
    import override_pkg::*;
    logic        clock;
    logic        reset;
    logic [11:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    sp_write_s   sp_in;
    sp_write_s   sp_out;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [1:0]  mode_v;
    logic [16:0] psel_v;
    logic        men_v;
    logic [16:0] msel_v;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [15:0] gp [5] = '{16'h001f, 16'h0020, 16'h003f, 16'h0040,
                            16'hffff};
    stim_port_override_select u_stim_port_override_select (.clock, .reset,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sp_in, .sp_out);
    sp_source u_sp_source (.clock, .sp(sp_in));
    initial
    begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end
    task automatic end_of_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // generous ceiling; the whole run needs a few hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // lowest one delimits the mask; bits above it are the prefix
    function automatic logic hit(logic [16:0] f, logic [15:0] n);
        for (int k = 0; k < 17; k++)
            if (f[k]) return (32'(n) >> k) == (32'(f) >> (k + 1));
        return 1'b0;
    endfunction
    task automatic prog(logic [1:0] m, logic [16:0] p, logic e,
                        logic [16:0] s);
        mode_v = m;
        psel_v = p;
        men_v = e;
        msel_v = s;
        axi_wr(PORT_OVR_OFFSET, {p, 13'h0000, m});
        `CHK(rs, AXI_OKAY)
        axi_wr(MASTER_OVR_OFFSET, {s, 14'h0000, e});
        `CHK(rs, AXI_OKAY)
        axi_rd(PORT_OVR_OFFSET);
        `CHK(rs, AXI_OKAY)
        `CHK(rd, {p, 13'h0000, m})
        axi_rd(MASTER_OVR_OFFSET);
        `CHK(rd, {s, 14'h0000, e})
    endtask
    task automatic chk_sp(logic [15:0] p, logic [15:0] ms, logic [1:0] f);
        sp_write_s d;
        logic o;
        d = {1'b1, p, ms, f};
        u_sp_source.send(d);
        #1;
        o = mode_v inside {2'h1, 2'h2} && hit(psel_v, p)
            && (!men_v || hit(msel_v, ms));
        if (o) d[1:0] = {mode_v == 2'h1, mode_v == 2'h2};
        `CHK(sp_out, d)
    endtask
    task automatic t_reset();
        `CHK(sp_out, 35'h0_0000_0000)
        axi_rd(PORT_OVR_OFFSET);
        `CHK(rd[1:0], MODE_RESET)
        axi_rd(MASTER_OVR_OFFSET);
        `CHK(rd[0], MENA_RESET)
        chk_sp(16'h0000, 16'h0000, 2'h0);
    endtask
    task automatic t_unmapped();
        axi_wr(12'h0008, 32'hffff_ffff);
        `CHK(rs, AXI_SLVERR)
        axi_rd(12'h0008);
        `CHK(rs, AXI_SLVERR)
        `CHK(rd, 32'h0000_0000)
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            prog(2'(m), {16'h0005, 1'b1}, 1'b0, 17'h0_0000);
            for (int p = 4; p < 7; p++)
            begin
                chk_sp(16'(p), 16'h0009, 2'h0);
                chk_sp(16'(p), 16'h0009, 2'h3);
            end
        end
    endtask
    task automatic t_groups();
        prog(2'h1, 17'h0_0060, 1'b0, 17'h0_0006);
        foreach (gp[i]) chk_sp(gp[i], 16'h0001, 2'h2);
        prog(2'h2, 17'h1_0000, 1'b0, 17'h0_0000);
        foreach (gp[i]) chk_sp(gp[i], 16'h0000, 2'h1);
    endtask
    task automatic t_masters();
        prog(2'h2, 17'h0_0060, 1'b1, 17'h0_0006);
        for (int ms = 1; ms < 5; ms++)
        begin
            chk_sp(16'h0020, 16'(ms), 2'h1);
            chk_sp(16'h0005, 16'(ms), 2'h1);
        end
        prog(2'h1, 17'h0_0060, 1'b1, 17'h1_0000);
        chk_sp(16'h0021, 16'h0000, 2'h2);
        chk_sp(16'h0021, 16'hffff, 2'h2);
    endtask
    initial
    begin
        reset = 1'b1;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_unmapped();
        t_modes();
        t_groups();
        t_masters();
        end_of_test();
    end
endmodule
